/* File: irq_ctl_map.svh */
// Operation
// - edge code: off, rise, fall, both
// - source event sets its flag, pin edge only when enabled
// - flag vectors only with own enable
// - global enable low blocks every interrupt
// - push next address, load source vector
// - every source has its own vector
// - return pops saved address into pc
// - taking interrupt clears global enable
// - flags still latch while service blocks
// - full stack blocks every acknowledge
// - flag rise wakes sleep, enables ignored
// - selected pin edge sets pin flag
// - pin is interrupt input only when enabled
// - pull-high stays valid in interrupt use
// - servicing pin clears pin flag
// - touch slot overflow sets touch flag
// - servicing touch clears touch flag
// - primary byte: flags 6..4, enables 3..0
// - secondary byte: flag bit5, enable bit1
// - edge register bits 7..2 read zero
// - counter overflow sets flag, service clears
// - timebase overflow sets flag, service clears
// - service return sets global, plain keeps
`ifndef IRQ_CTL_MAP_SVH
`define IRQ_CTL_MAP_SVH

// ==========================================================
// register selects
`define REG_EDGE_SELECT      2'h0
`define REG_PRIMARY_CONTROL  2'h1
`define REG_SECONDARY_CONTROL 2'h2

// ==========================================================
// field positions
`define EDGE_SEL_HI          1
`define PRI_COUNTER_FLAG     6
`define PRI_TOUCH_FLAG       5
`define PRI_PIN_FLAG         4
`define PRI_COUNTER_ENABLE   3
`define PRI_TOUCH_ENABLE     2
`define PRI_PIN_ENABLE       1
`define PRI_GLOBAL_ENABLE    0
`define SEC_TIMEBASE_FLAG    5
`define SEC_TIMEBASE_ENABLE  1

// ==========================================================
// reset values, sizes, vectors
`define REG_RESET            8'h00
`define PC_W                 11
`define STACK_DEPTH          6
`define STACK_PTR_W          3
`define VEC_PIN              11'h004
`define VEC_TOUCH            11'h008
`define VEC_COUNTER          11'h00C
`define VEC_TIMEBASE         11'h010

`endif

/* File: irq_ctl_pkg.sv */
`include "irq_ctl_map.svh"
package irq_ctl_pkg;
   typedef logic [`PC_W-1:0] pc_t;
   typedef enum logic [2:0] {
      ST_IDLE    = 3'b001,
      ST_SERVICE = 3'b010,
      ST_RESUME  = 3'b100
   } svc_state_t;
   typedef enum logic [1:0] {
      EDGE_OFF  = 2'b00,
      EDGE_RISE = 2'b01,
      EDGE_FALL = 2'b10,
      EDGE_BOTH = 2'b11
   } edge_sel_t;
endpackage : irq_ctl_pkg

/* File: return_stack.sv */
`timescale 1ns/1ps
`include "irq_ctl_map.svh"
module return_stack
(
   input  wire logic             clk,      // system clock
   input  wire logic             rstN,     // synchronised reset
   input  wire logic             push,     // store pushData
   input  wire logic             pop,      // remove top entry
   input  wire irq_ctl_pkg::pc_t pushData, // address to save
   output irq_ctl_pkg::pc_t      popData,  // popped address, registered
   output logic                  full,     // no room left
   output logic                  empty     // nothing saved
);
   import irq_ctl_pkg::*;

   pc_t                     mem [`STACK_DEPTH];
   logic [`STACK_PTR_W-1:0] depth;

   assign full  = (depth == `STACK_PTR_W'(`STACK_DEPTH));
   assign empty = (depth == '0);

   // ==========================================================
   // pointer: push onto free slot, pop from top
   always_ff @(posedge clk or negedge rstN)
   begin
      if (!rstN)
         depth <= '0;
      else if (push && !full)
         depth <= depth + `STACK_PTR_W'(1);
      else if (pop && !empty)
         depth <= depth - `STACK_PTR_W'(1);
   end

   // storage array
   always_ff @(posedge clk)
   begin
      if (push && !full)
         mem[depth] <= pushData;
   end

   // read data register
   always_ff @(posedge clk or negedge rstN)
   begin
      if (!rstN)
         popData <= '0;
      else if (pop && !empty)
         popData <= mem[depth - `STACK_PTR_W'(1)];
   end
endmodule : return_stack

/* File: interrupt_controller.sv */
`timescale 1ns/1ps
`include "irq_ctl_map.svh"
module interrupt_controller
(
   input  wire logic             clk,             // 40 MHz system clock
   input  wire logic             nrst,            // power-on reset, low
   input  wire logic [1:0]       regAddr,         // register select
   input  wire logic             regWrite,        // write strobe
   input  wire logic [7:0]       regWdata,        // write data
   output logic      [7:0]       regRdata,        // read data, registered
   input  wire logic             extPin,          // shared pin, async
   input  wire logic             pullHighSel,     // port pull-high choice
   output logic                  pinPullUpEn,     // pull-high to pad
   output logic                  pinIrqMode,      // pin used as irq input
   input  wire logic             touchOverflow,   // slot counter overflow
   input  wire logic             counterOverflow, // timer overflow
   input  wire logic             timebaseOverflow,// time base overflow
   input  wire logic             instrBoundary,   // core may be interrupted
   input  wire irq_ctl_pkg::pc_t nextPc,          // next instruction address
   input  wire logic             callPush,        // subroutine call
   input  wire logic             retPop,          // plain return
   input  wire logic             retiPop,         // return_from_service
   input  wire logic             sleepMode,       // core in sleep or idle
   output logic                  irqTake,         // interrupt taken, pulse
   output logic                  pcLoad,          // load pc, pulse
   output irq_ctl_pkg::pc_t      pcTarget,        // pc value to load
   output logic                  stackFull,       // return stack full
   output logic                  wakeUp           // wake pulse
);
   import irq_ctl_pkg::*;

   // ==========================================================
   // reset release
   logic rstMeta;
   logic rstN;

   // two-stage release of the asynchronous reset
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         rstMeta <= 1'b0;
         rstN    <= 1'b0;
      end
      else
      begin
         rstMeta <= 1'b1;
         rstN    <= rstMeta;
      end
   end

   // ==========================================================
   // register state
   edge_sel_t  pin_edge_select;
   logic       global_irq_enable;
   logic [3:0] srcEnable;  // pin, touch, counter, timebase
   logic [3:0] srcFlag;    // same order
   logic [3:0] srcEvent;
   logic [3:0] flagWe;
   logic [3:0] flagWdata;
   logic [3:0] svcClear;
   logic [3:0] prevFlag;
   svc_state_t state;
   svc_state_t next_state;
   logic [1:0] chosen;
   logic [3:0] ready;
   logic       takeOk;
   logic       retAccept;
   logic       retiAccept;
   logic       stackEmpty;
   pc_t        popData;
   logic       wrEdge;
   logic       wrPri;
   logic       wrSec;

   assign wrEdge = regWrite && (regAddr == `REG_EDGE_SELECT);
   assign wrPri  = regWrite && (regAddr == `REG_PRIMARY_CONTROL);
   assign wrSec  = regWrite && (regAddr == `REG_SECONDARY_CONTROL);

   // ==========================================================
   // external pin
   logic pinSync1;
   logic pinSync2;
   logic pinLast;
   logic pinRise;
   logic pinFall;
   logic pinEdge;

   // synchroniser and edge history
   always_ff @(posedge clk or negedge rstN)
   begin
      if (!rstN)
      begin
         pinSync1 <= 1'b0;
         pinSync2 <= 1'b0;
         pinLast  <= 1'b0;
      end
      else
      begin
         pinSync1 <= extPin;
         pinSync2 <= pinSync1;
         pinLast  <= pinSync2;
      end
   end

   assign pinRise = pinSync2 && !pinLast;
   assign pinFall = !pinSync2 && pinLast;

   always_comb
   begin
      case (pin_edge_select)
         EDGE_OFF:  pinEdge = 1'b0;
         EDGE_RISE: pinEdge = pinRise;
         EDGE_FALL: pinEdge = pinFall;
         EDGE_BOTH: pinEdge = pinRise || pinFall;
         default:   pinEdge = 1'b0;
      endcase
   end

   // pin serves as irq input only when enabled
   assign pinIrqMode  = srcEnable[0];
   // pull-high passes through in either use
   assign pinPullUpEn = pullHighSel;

   assign srcEvent = {timebaseOverflow, counterOverflow, touchOverflow,
                      pinEdge && srcEnable[0]};

   // ==========================================================
   // software writes to the flags
   // flag positions in the bytes
   assign flagWe    = {wrSec, wrPri, wrPri, wrPri};
   assign flagWdata = {regWdata[`SEC_TIMEBASE_FLAG],
                       regWdata[`PRI_COUNTER_FLAG],
                       regWdata[`PRI_TOUCH_FLAG],
                       regWdata[`PRI_PIN_FLAG]};

   assign svcClear = irqTake ? (4'h1 << chosen) : 4'h0;

   // event sets flag over any clear
   generate
      for (genvar i = 0; i < 4; i++)
      begin : g_flag
         always_ff @(posedge clk or negedge rstN)
         begin
            if (!rstN)
               srcFlag[i] <= 1'b0;
            else if (srcEvent[i])
               srcFlag[i] <= 1'b1;
            else if (svcClear[i])
               srcFlag[i] <= 1'b0;
            else if (flagWe[i])
               srcFlag[i] <= flagWdata[i];
         end
      end
   endgenerate

   // ==========================================================
   // enables and edge select
   always_ff @(posedge clk or negedge rstN)
   begin
      if (!rstN)
      begin
         pin_edge_select <= EDGE_OFF;
         srcEnable       <= 4'h0;
      end
      else
      begin
         if (wrEdge)
            pin_edge_select <= edge_sel_t'(regWdata[`EDGE_SEL_HI:0]);
         if (wrPri)
            srcEnable[2:0] <= {regWdata[`PRI_COUNTER_ENABLE],
                               regWdata[`PRI_TOUCH_ENABLE],
                               regWdata[`PRI_PIN_ENABLE]};
         if (wrSec)
            srcEnable[3] <= regWdata[`SEC_TIMEBASE_ENABLE];
      end
   end

   // global enable: service clear beats return set beats write
   always_ff @(posedge clk or negedge rstN)
   begin
      if (!rstN)
         global_irq_enable <= 1'b0;
      // taking an interrupt clears global enable
      else if (irqTake)
         global_irq_enable <= 1'b0;
      else if (retiAccept)
         global_irq_enable <= 1'b1;
      // software may set it again to nest
      else if (wrPri)
         global_irq_enable <= regWdata[`PRI_GLOBAL_ENABLE];
   end

   // ==========================================================
   // read back
   // unused bits read zero
   always_ff @(posedge clk or negedge rstN)
   begin
      if (!rstN)
         regRdata <= `REG_RESET;
      else
      begin
         case (regAddr)
            `REG_EDGE_SELECT:
               regRdata <= {6'h00, pin_edge_select};
            `REG_PRIMARY_CONTROL:
               regRdata <= {1'b0, srcFlag[2:0], srcEnable[2:0],
                            global_irq_enable};
            `REG_SECONDARY_CONTROL:
               regRdata <= {2'h0, srcFlag[3], 3'h0, srcEnable[3], 1'b0};
            default:
               regRdata <= `REG_RESET;
         endcase
      end
   end

   // ==========================================================
   // arbitration
   // flag counts only with its own enable
   assign ready = srcFlag & srcEnable;

   // lowest index wins: pin, touch, counter, timebase
   always_comb
   begin
      chosen = 2'h0;
      for (int i = 3; i >= 0; i--)
      begin
         if (ready[i])
            chosen = 2'(i);
      end
   end

   function automatic pc_t vecOf(input logic [1:0] src);
      case (src)
         2'h0:    vecOf = `VEC_PIN;
         2'h1:    vecOf = `VEC_TOUCH;
         2'h2:    vecOf = `VEC_COUNTER;
         default: vecOf = `VEC_TIMEBASE;
      endcase
   endfunction : vecOf

   // global enable and stack room both needed
   assign takeOk = global_irq_enable && (|ready) && !stackFull &&
                   instrBoundary && (state == ST_IDLE) && !pcLoad &&
                   !retPop && !retiPop && !callPush;
   assign irqTake    = takeOk;
   assign retAccept  = retPop && !stackEmpty && (state == ST_IDLE);
   assign retiAccept = retiPop && !stackEmpty && (state == ST_IDLE);

   // ==========================================================
   // service sequencer
   always_comb
   begin
      case (state)
         ST_IDLE:
            if (irqTake)
               next_state = ST_SERVICE;
            else if (retAccept || retiAccept)
               next_state = ST_RESUME;
            else
               next_state = ST_IDLE;
         ST_SERVICE: next_state = ST_IDLE;
         ST_RESUME:  next_state = ST_IDLE;
         default:    next_state = ST_IDLE;
      endcase
   end

   always_ff @(posedge clk or negedge rstN)
   begin
      if (!rstN)
         state <= ST_IDLE;
      else
         state <= next_state;
   end

   // pc load: vector after take, popped pc after return
   always_ff @(posedge clk or negedge rstN)
   begin
      if (!rstN)
      begin
         pcLoad   <= 1'b0;
         pcTarget <= '0;
      end
      else if (irqTake)
      begin
         pcLoad   <= 1'b1;
         pcTarget <= vecOf(chosen);
      end
      else if (state == ST_RESUME)
      begin
         pcLoad   <= 1'b1;
         pcTarget <= popData;
      end
      else
         pcLoad <= 1'b0;
   end

   // push next address on take or call
   return_stack u_stack
   (
      .clk      (clk),
      .rstN     (rstN),
      .push     (irqTake || callPush),
      .pop      (retAccept || retiAccept),
      .pushData (nextPc),
      .popData  (popData),
      .full     (stackFull),
      .empty    (stackEmpty)
   );

   // ==========================================================
   // wake-up
   // flag rise during sleep wakes, enables ignored
   always_ff @(posedge clk or negedge rstN)
   begin
      if (!rstN)
      begin
         prevFlag <= 4'h0;
         wakeUp   <= 1'b0;
      end
      else
      begin
         prevFlag <= srcFlag;
         wakeUp   <= sleepMode && (|(srcFlag & ~prevFlag));
      end
   end

   // ==========================================================
   // assertions
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstN);

   a_take_needs_global: assert property (
      irqTake |-> global_irq_enable)
      else $error("interrupt taken with global enable low");

   a_take_needs_enable: assert property (
      irqTake |-> srcFlag[chosen] && srcEnable[chosen])
      else $error("interrupt taken for a disabled source");

   a_full_blocks: assert property (
      stackFull |-> !irqTake)
      else $error("interrupt taken with full stack");

   a_take_clears_global: assert property (
      irqTake |=> !global_irq_enable)
      else $error("global enable not cleared by service");

   a_take_loads_vector: assert property (
      irqTake |=> pcLoad && pcTarget == vecOf($past(chosen)))
      else $error("vector not loaded after take");

   a_pin_flag_clear: assert property (
      irqTake && chosen == 2'h0 && !srcEvent[0] |=> !srcFlag[0])
      else $error("pin flag not cleared on service");

   a_touch_sets_flag: assert property (
      touchOverflow |=> srcFlag[1])
      else $error("touch overflow did not set flag");

   a_return_from_service_sets_global: assert property (
      retiAccept && !irqTake |=> global_irq_enable)
      else $error("service return left global enable low");

   a_ret_keeps_global: assert property (
      retAccept && !wrPri |=> $stable(global_irq_enable))
      else $error("plain return changed global enable");

   a_return_loads_pc: assert property (
      retAccept || retiAccept |-> ##2 pcLoad)
      else $error("popped address not loaded");

   a_wake_needs_sleep: assert property (
      wakeUp |-> $past(sleepMode))
      else $error("wake pulse outside sleep");

   a_edge_reads_zero: assert property (
      regAddr == `REG_EDGE_SELECT |=> regRdata[7:2] == 6'h00)
      else $error("edge register upper bits not zero");

   c_take_pin:     cover property (irqTake && chosen == 2'h0);
   c_take_blocked: cover property (|ready && global_irq_enable && stackFull);
   c_return_from_service_round:   cover property (irqTake ##[1:50] retiAccept);
   c_wake:         cover property (wakeUp);
endmodule : interrupt_controller

/* File: core_model.sv */
`timescale 1ns/1ps
module core_model
(
   input  wire logic             clk,           // system clock
   input  wire logic             runEn,         // bench allows irq entry
   input  wire logic             irqTake,       // take pulse from block
   input  wire logic             pcLoad,        // load request
   input  wire irq_ctl_pkg::pc_t pcTarget,      // value to load
   output logic                  instrBoundary, // interruptible point
   output irq_ctl_pkg::pc_t      nextPc,        // next fetch address
   output irq_ctl_pkg::pc_t      pc,            // current fetch address
   output int                    takes          // taken interrupts so far
);
   import irq_ctl_pkg::*;
   pc_t pcReg = '0;
   int  takeCnt = 0;
   // ==========================================================
   // sequencer side of the core
   assign instrBoundary = runEn;
   assign pc = pcReg;
   assign takes = takeCnt;
   // pushed address is the next one
   assign nextPc = pcReg + 11'h001;
   always @(posedge clk)
   begin
      if (pcLoad === 1'b1)
         pcReg <= pcTarget;
      if (irqTake === 1'b1)
         takeCnt <= takeCnt + 1;
   end
endmodule : core_model

/* File: tb_top.sv */
`timescale 1ns/1ps
`include "irq_ctl_map.svh"
module tb_top;
   import irq_ctl_pkg::*;
   localparam logic [1:0] EDG = `REG_EDGE_SELECT;
   localparam logic [1:0] PRI = `REG_PRIMARY_CONTROL;
   localparam logic [1:0] SEC = `REG_SECONDARY_CONTROL;
   logic       clk = 1'b0, nrst = 1'b0, regWrite = 1'b0;
   logic [1:0] regAddr = 2'h0;
   logic [7:0] regWdata = 8'h00, regRdata;
   logic       extPin = 1'b0, pullHighSel = 1'b1, pinPullUpEn, pinIrqMode;
   logic       touchOverflow = 1'b0, counterOverflow = 1'b0;
   logic       timebaseOverflow = 1'b0, runEn = 1'b1, sleepMode = 1'b0;
   logic       callPush = 1'b0, retPop = 1'b0, retiPop = 1'b0;
   logic       irqTake, pcLoad, stackFull, wakeUp, instrBoundary;
   pc_t        pcTarget, nextPc, pc, pcExp;
   int         takes, t, w, errors = 0, cmp_count = 0, wakes = 0;
   pc_t        vecs [4] = '{`VEC_PIN, `VEC_TOUCH, `VEC_COUNTER, `VEC_TIMEBASE};
   // ==========================================================
   // clock, wake monitor, instances
   always #12.5 clk = ~clk;
   always @(negedge clk)
      if (wakeUp === 1'b1)
         wakes++;
   interrupt_controller i_dut (.clk(clk), .nrst(nrst), .regAddr(regAddr),
      .regWrite(regWrite), .regWdata(regWdata), .regRdata(regRdata),
      .extPin(extPin), .pullHighSel(pullHighSel), .pinPullUpEn(pinPullUpEn),
      .pinIrqMode(pinIrqMode), .touchOverflow(touchOverflow),
      .counterOverflow(counterOverflow), .timebaseOverflow(timebaseOverflow),
      .instrBoundary(instrBoundary), .nextPc(nextPc), .callPush(callPush),
      .retPop(retPop), .retiPop(retiPop), .sleepMode(sleepMode),
      .irqTake(irqTake), .pcLoad(pcLoad), .pcTarget(pcTarget),
      .stackFull(stackFull), .wakeUp(wakeUp));
   core_model i_core (.clk(clk), .runEn(runEn), .irqTake(irqTake),
      .pcLoad(pcLoad), .pcTarget(pcTarget), .instrBoundary(instrBoundary),
      .nextPc(nextPc), .pc(pc), .takes(takes));
   // ==========================================================
   // access and compare tasks
   task tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : tick
   task stop_test;
      $display("errors %0d compares %0d", errors, cmp_count);
      if (errors == 0 && cmp_count > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : stop_test
   task chk_byte(input logic [7:0] g, input logic [7:0] e);
      cmp_count++;
      if (g !== e)
      begin
         errors++;
         $display("[ERR] %0t byte %h expected %h", $time, g, e);
      end
   endtask : chk_byte
   task chk_bit(input logic g, input logic e);
      cmp_count++;
      if (g !== e)
      begin
         errors++;
         $display("[ERR] %0t bit %b expected %b", $time, g, e);
      end
   endtask : chk_bit
   task chk_pc(input pc_t g, input pc_t e);
      cmp_count++;
      if (g !== e)
      begin
         errors++;
         $display("[ERR] %0t pc %h expected %h", $time, g, e);
      end
   endtask : chk_pc
   task wr(input logic [1:0] a, input logic [7:0] d);
      regAddr = a;
      regWdata = d;
      regWrite = 1'b1;
      tick(1);
      regWrite = 1'b0;
      tick(1);
   endtask : wr
   task rd(input logic [1:0] a, input logic [7:0] e);
      regAddr = a;
      tick(1);
      chk_byte(regRdata, e);
   endtask : rd
   task automatic pulse(ref logic s);
      s = 1'b1;
      tick(1);
      s = 1'b0;
   endtask : pulse
   task wait_load(input pc_t e);
      for (int i = 0; i < 30 && pcLoad !== 1'b1; i++)
         tick(1);
      if (pcLoad !== 1'b1)
      begin
         errors++;
         $display("[ERR] %0t no pc load", $time);
         stop_test;
      end
      chk_pc(pcTarget, e);
      tick(1);
   endtask : wait_load
   task reset_dut;
      nrst = 1'b0;
      tick(5);
      nrst = 1'b1;
      tick(3);
   endtask : reset_dut
   // ==========================================================
   // main sequence
   initial
   begin
      reset_dut;
      for (int a = 0; a < 4; a++)
         rd(2'(a), 8'h00);
      wr(EDG, 8'hFF);
      rd(EDG, 8'h03);
      wr(PRI, 8'hFE);
      rd(PRI, 8'h7E);
      wr(SEC, 8'hFF);
      rd(SEC, 8'h22);
      wr(PRI, 8'h00);
      wr(SEC, 8'h00);
      wr(EDG, 8'h00);
      // counter source, gating and service
      pulse(counterOverflow);
      rd(PRI, 8'h40);
      t = takes;
      wr(PRI, 8'h41);
      tick(8);
      chk_bit(takes == t, 1'b1);
      wr(PRI, 8'h48);
      tick(8);
      chk_bit(takes == t, 1'b1);
      pcExp = pc;
      wr(PRI, 8'h49);
      wait_load(`VEC_COUNTER);
      rd(PRI, 8'h08);
      pulse(touchOverflow);
      rd(PRI, 8'h28);
      wr(PRI, 8'h29);
      rd(PRI, 8'h29);
      pulse(retiPop);
      wait_load(pcExp + 11'h001);
      rd(PRI, 8'h29);
      wr(PRI, 8'h08);
      pcExp = pc;
      pulse(callPush);
      tick(1);
      pulse(retPop);
      wait_load(pcExp + 11'h001);
      rd(PRI, 8'h08);
      // pin edge codes; the bench only drives the pin as an input
      for (int c = 0; c < 4; c++)
      begin
         wr(EDG, 2'(c));
         for (int d = 0; d < 2; d++)
         begin
            wr(PRI, 8'h02);
            extPin = (d == 0);
            tick(8);
            rd(PRI, ((c >> d) & 1) ? 8'h12 : 8'h02);
         end
      end
      chk_bit(pinIrqMode, 1'b1);
      chk_bit(pinPullUpEn, 1'b1);
      pullHighSel = 1'b0;
      tick(1);
      chk_bit(pinPullUpEn, 1'b0);
      wr(PRI, 8'h00);
      chk_bit(pinIrqMode, 1'b0);
      extPin = 1'b1;
      tick(8);
      rd(PRI, 8'h00);
      extPin = 1'b0;
      tick(8);
      // all four pending, served in order
      wr(EDG, 8'h01);
      wr(SEC, 8'h02);
      wr(PRI, 8'h0E);
      pulse(touchOverflow);
      pulse(counterOverflow);
      pulse(timebaseOverflow);
      extPin = 1'b1;
      tick(8);
      rd(PRI, 8'h7E);
      rd(SEC, 8'h22);
      pcExp = pc;
      wr(PRI, 8'h7F);
      for (int i = 0; i < 4; i++)
      begin
         wait_load(vecs[i]);
         pulse(retiPop);
         wait_load(pcExp + 11'h001);
         pcExp = pcExp + 11'h001;
      end
      rd(PRI, 8'h0F);
      rd(SEC, 8'h02);
      // full stack holds off a pending request
      wr(PRI, 8'h08);
      pcExp = pc;
      repeat (6)
      begin
         pulse(callPush);
         tick(1);
      end
      chk_bit(stackFull, 1'b1);
      t = takes;
      wr(PRI, 8'h49);
      tick(10);
      chk_bit(takes == t, 1'b1);
      pulse(retPop);
      wait_load(pcExp + 11'h001);
      wait_load(`VEC_COUNTER);
      // second reset, then wake from sleep
      reset_dut;
      rd(PRI, 8'h00);
      sleepMode = 1'b1;
      w = wakes;
      pulse(timebaseOverflow);
      tick(4);
      chk_bit(wakes == w + 1, 1'b1);
      pulse(timebaseOverflow);
      tick(4);
      chk_bit(wakes == w + 1, 1'b1);
      rd(SEC, 8'h20);
      stop_test;
   end
endmodule : tb_top
